// >>> sideband_pkg.sv
// constants for the optical module sideband controller
package sideband_pkg;
	localparam int unsigned CLOCK_MHZ = 250;
	// times in their own unit, as printed
	localparam int unsigned OFF_TIME_US = 100;
	localparam int unsigned ON_TIME_MS = 2;
	localparam int unsigned TWO_WIRE_START_MS = 300;
	localparam int unsigned START_UP_MS = 300;
	localparam int unsigned START_UP_COOLED_S = 90;
	localparam int unsigned LEVEL2_UP_MS = 300;
	localparam int unsigned LEVEL2_DOWN_MS = 300;
	localparam int unsigned FAULT_ON_MS = 1;
	localparam int unsigned FAULT_ON_COOLED_MS = 50;
	localparam int unsigned FAULT_RESET_US = 10;
	localparam int unsigned RATE_FC_US = 500;
	localparam int unsigned RATE_NON_FC_MS = 10;
	localparam int unsigned LOS_ON_US = 100;
	localparam int unsigned LOS_OFF_US = 100;
	// a 1 us tick drives every timer
	localparam int unsigned TICK_CYCLES = CLOCK_MHZ;
	localparam int unsigned TICK_W = 8;
	localparam int unsigned TIMER_W = 27;
	// synchroniser value after reset: {off request, rate 0, rate 1, stop bit, fault, signal}
	// off request pulled high and signal present, so no false edge follows reset
	localparam logic [5:0] PIN_IDLE = 6'h21;
	// counts in 1 us ticks; every time converts to a whole number of ticks with no rounding
	localparam logic [TIMER_W-1:0] OFF_TICKS = TIMER_W'(OFF_TIME_US);
	localparam logic [TIMER_W-1:0] ON_TICKS = TIMER_W'(ON_TIME_MS * 1000);
	localparam logic [TIMER_W-1:0] TWO_WIRE_TICKS = TIMER_W'(TWO_WIRE_START_MS * 1000);
	localparam logic [TIMER_W-1:0] START_TICKS = TIMER_W'(START_UP_MS * 1000);
	localparam logic [TIMER_W-1:0] START_COOLED_TICKS = TIMER_W'(START_UP_COOLED_S * 1000000);
	localparam logic [TIMER_W-1:0] LEVEL2_UP_TICKS = TIMER_W'(LEVEL2_UP_MS * 1000);
	localparam logic [TIMER_W-1:0] LEVEL2_DOWN_TICKS = TIMER_W'(LEVEL2_DOWN_MS * 1000);
	localparam logic [TIMER_W-1:0] FAULT_ON_TICKS = TIMER_W'(FAULT_ON_MS * 1000);
	localparam logic [TIMER_W-1:0] FAULT_COOLED_TICKS = TIMER_W'(FAULT_ON_COOLED_MS * 1000);
	localparam logic [TIMER_W-1:0] FAULT_RESET_TICKS = TIMER_W'(FAULT_RESET_US);
	localparam logic [TIMER_W-1:0] RATE_FC_TICKS = TIMER_W'(RATE_FC_US);
	localparam logic [TIMER_W-1:0] RATE_NON_FC_TICKS = TIMER_W'(RATE_NON_FC_MS * 1000);
	localparam logic [TIMER_W-1:0] LOS_ON_TICKS = TIMER_W'(LOS_ON_US);
	localparam logic [TIMER_W-1:0] LOS_OFF_TICKS = TIMER_W'(LOS_OFF_US);
	typedef enum logic [2:0] {
		ST_START,
		ST_OFF,
		ST_RAMP,
		ST_ON,
		ST_FAULT
	} tx_state_t;
endpackage

// >>> deadline_timer.sv
// down counter on the 1 us tick that reports when a started interval has expired
`timescale 1ns/1ps
`default_nettype none
module deadline_timer #(
	parameter int unsigned WIDTH = 27
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic start,
	input wire logic [WIDTH-1:0] length,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] count;
	wire last = busy && tick && (count <= WIDTH'(1));
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= last && !start;
			if (start) begin
				count <= length;
				busy <= 1'b1;
			end else if (last) begin
				count <= '0;
				busy <= 1'b0;
			end else if (busy && tick) begin
				count <= count - WIDTH'(1);
			end
		end
	end
endmodule
`default_nettype wire

// >>> optical_module_sideband_control.sv
// sideband control and status logic of a pluggable optical transceiver module
`timescale 1ns/1ps
`default_nettype none
module optical_module_sideband_control
	import sideband_pkg::*;
#(
	parameter bit COOLED = 1'b0,
	parameter logic [TIMER_W-1:0] START_LEN = START_TICKS,
	parameter logic [TIMER_W-1:0] START_COOLED_LEN = START_COOLED_TICKS,
	parameter logic [TIMER_W-1:0] TWO_WIRE_LEN = TWO_WIRE_TICKS,
	parameter logic [TIMER_W-1:0] LEVEL2_UP_LEN = LEVEL2_UP_TICKS,
	parameter logic [TIMER_W-1:0] LEVEL2_DOWN_LEN = LEVEL2_DOWN_TICKS,
	parameter logic [TIMER_W-1:0] ON_LEN = ON_TICKS,
	parameter logic [TIMER_W-1:0] FAULT_LEN = COOLED ? FAULT_COOLED_TICKS : FAULT_ON_TICKS,
	parameter logic [TIMER_W-1:0] RATE_NON_FC_LEN = RATE_NON_FC_TICKS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tx_off_request,
	input wire logic rate_select_zero,
	input wire logic rate_select_one,
	input wire logic fibre_channel_mode,
	input wire logic level2_stop_bit,
	input wire logic laser_fault,
	input wire logic rx_signal_present,
	output logic laser_enable,
	output logic tx_ready,
	output logic tx_fault_oe,
	output logic tx_fault_out,
	output logic rx_los,
	output logic two_wire_ready,
	output logic module_ready,
	output logic power_level2,
	output logic rate_stable
);
	// ---------------------------------------------------------------
	// input synchronisers and 1 us tick
	// ---------------------------------------------------------------
	localparam int unsigned NSYNC = 6;
	wire [NSYNC-1:0] raw_in = {tx_off_request, rate_select_zero, rate_select_one,
		level2_stop_bit, laser_fault, rx_signal_present};
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic [NSYNC-1:0] sync_prev;
	logic [TICK_W-1:0] tick_count;
	logic tick;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync_a <= PIN_IDLE;
			sync_b <= PIN_IDLE;
			sync_prev <= PIN_IDLE;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			sync_prev <= sync_b;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tick_count <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (tick_count == TICK_W'(TICK_CYCLES - 1));
			tick_count <= (tick_count == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_count + TICK_W'(1);
		end
	end
	wire off_req = sync_b[5];
	wire off_rise = sync_b[5] && !sync_prev[5];
	wire off_fall = !sync_b[5] && sync_prev[5];
	wire rate_change = (sync_b[4] != sync_prev[4]) || (sync_b[3] != sync_prev[3]);
	wire stop_fall = !sync_b[2] && sync_prev[2];
	wire fault_in = sync_b[1];
	wire sig_present = sync_b[0];
	// ---------------------------------------------------------------
	// timers
	// ---------------------------------------------------------------
	localparam int unsigned NT = 8;
	localparam int unsigned T_START = 0;
	localparam int unsigned T_2W = 1;
	localparam int unsigned T_ON = 2;
	localparam int unsigned T_FAULT = 3;
	localparam int unsigned T_RESET = 4;
	localparam int unsigned T_RATE = 5;
	localparam int unsigned T_LOS = 6;
	localparam int unsigned T_LVL = 7;
	logic [NT-1:0] t_start;
	logic [NT-1:0] t_busy;
	logic [NT-1:0] t_done;
	logic [TIMER_W-1:0] t_len [NT];
	logic powered;
	tx_state_t state;
	tx_state_t next_state;
	logic fault_flag;
	logic los;
	logic lvl2_target;
	wire startup_len_sel = COOLED;
	wire [TIMER_W-1:0] start_len = startup_len_sel ? START_COOLED_LEN : START_LEN;
	assign t_len[T_START] = start_len;
	assign t_len[T_2W] = TWO_WIRE_LEN;
	assign t_len[T_ON] = ON_LEN;
	assign t_len[T_FAULT] = FAULT_LEN;
	assign t_len[T_RESET] = FAULT_RESET_TICKS;
	assign t_len[T_RATE] = fibre_channel_mode ? RATE_FC_TICKS : RATE_NON_FC_LEN;
	assign t_len[T_LOS] = los ? LOS_OFF_TICKS : LOS_ON_TICKS;
	assign t_len[T_LVL] = lvl2_target ? LEVEL2_DOWN_LEN : LEVEL2_UP_LEN;
	genvar gi;
	generate
		for (gi = 0; gi < NT; gi++) begin : g_timer
			deadline_timer #(.WIDTH(TIMER_W)) u_timer (
				.clock(clock),
				.rst_n(rst_n),
				.tick(tick),
				.start(t_start[gi]),
				.length(t_len[gi]),
				.busy(t_busy[gi]),
				.done(t_done[gi])
			);
		end
	endgenerate
	// ---------------------------------------------------------------
	// timer starts
	// ---------------------------------------------------------------
	wire fault_pending = fault_in && !fault_flag && !t_busy[T_FAULT];
	wire los_mismatch = (los == sig_present) && !t_busy[T_LOS];
	wire enter_recover = (state == ST_FAULT) && off_fall && !fault_in;
	wire enter_start_off = (state == ST_START) && off_fall;
	assign t_start[T_START] = !powered || enter_recover;
	assign t_start[T_2W] = !powered;
	assign t_start[T_ON] = (state == ST_OFF) && !off_req;
	assign t_start[T_FAULT] = fault_pending;
	assign t_start[T_RESET] = off_rise && fault_flag;
	assign t_start[T_RATE] = rate_change;
	assign t_start[T_LOS] = los_mismatch;
	assign t_start[T_LVL] = stop_fall;
	// ---------------------------------------------------------------
	// transmitter state machine
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_START: begin
				if (t_done[T_START]) begin
					next_state = off_req ? ST_OFF : ST_ON;
				end
			end
			ST_OFF: begin
				if (!off_req) begin
					next_state = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (off_req) begin
					next_state = ST_OFF;
				end else if (t_done[T_ON]) begin
					next_state = ST_ON;
				end
			end
			ST_ON: begin
				if (off_req) begin
					next_state = ST_OFF;
				end
			end
			ST_FAULT: begin
				if (enter_recover) begin
					next_state = ST_START;
				end
			end
			default: begin
				next_state = ST_START;
			end
		endcase
		if (fault_flag && state != ST_START) begin
			next_state = ST_FAULT;
		end
		if (enter_start_off) begin
			next_state = ST_START;
		end
	end
	// ---------------------------------------------------------------
	// state, flags and outputs
	// ---------------------------------------------------------------
	wire fault_clear = t_done[T_RESET] && off_req;
	wire fault_set = t_done[T_FAULT] && fault_in;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			powered <= 1'b0;
			state <= ST_START;
			fault_flag <= 1'b0;
			los <= 1'b1;
			lvl2_target <= 1'b0;
		end else begin
			powered <= 1'b1;
			state <= next_state;
			fault_flag <= fault_set || (fault_flag && !fault_clear);
			if (t_done[T_LOS] && (los == sig_present)) begin
				los <= !sig_present;
			end
			if (t_done[T_LVL]) begin
				lvl2_target <= !lvl2_target;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			laser_enable <= 1'b0;
			tx_ready <= 1'b0;
			tx_fault_oe <= 1'b0;
			tx_fault_out <= 1'b0;
			rx_los <= 1'b1;
			two_wire_ready <= 1'b0;
			module_ready <= 1'b0;
			power_level2 <= 1'b0;
			rate_stable <= 1'b0;
		end else begin
			laser_enable <= !off_req && !fault_flag && (state == ST_RAMP || state == ST_ON);
			tx_ready <= (state == ST_ON) && !off_req && !fault_flag;
			tx_fault_oe <= !fault_flag;
			tx_fault_out <= 1'b0;
			rx_los <= los;
			two_wire_ready <= two_wire_ready || t_done[T_2W];
			module_ready <= (state == ST_ON || state == ST_OFF || state == ST_RAMP);
			power_level2 <= lvl2_target && !t_busy[T_LVL];
			rate_stable <= !t_busy[T_RATE] && !rate_change;
		end
	end
endmodule
`default_nettype wire

// >>> sideband_asserts.sv
// assertions on the ports of the sideband controller
`timescale 1ns/1ps
`default_nettype none
module sideband_asserts
	import sideband_pkg::*;
#(
	parameter logic [TIMER_W-1:0] TWO_WIRE_LEN = TWO_WIRE_TICKS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tx_off_request,
	input wire logic rate_select_zero,
	input wire logic rate_select_one,
	input wire logic fibre_channel_mode,
	input wire logic level2_stop_bit,
	input wire logic laser_fault,
	input wire logic rx_signal_present,
	input wire logic laser_enable,
	input wire logic tx_ready,
	input wire logic tx_fault_oe,
	input wire logic tx_fault_out,
	input wire logic rx_los,
	input wire logic two_wire_ready,
	input wire logic module_ready,
	input wire logic power_level2,
	input wire logic rate_stable
);
	localparam int TW_LIM = int'(TWO_WIRE_LEN) * 250 + 300;
	localparam int LOS_LIM = 25300;
	int since_reset;
	int since_rx;
	logic flagged;
	// flagged: a fault flag was raised and no off request has been seen since
	always_ff @(posedge clock) begin
		since_reset <= !rst_n ? 0 : since_reset + 1;
		since_rx <= (!rst_n || $changed(rx_signal_present)) ? 0 : since_rx + 1;
		flagged <= (!rst_n || tx_off_request) ? 1'b0 : (flagged || $fell(tx_fault_oe));
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	off_resp_a: assert property ($rose(tx_off_request) |-> ##[1:1000] !laser_enable)
		else $error("laser still on after off request");
	off_hold_a: assert property (tx_off_request [*8] |-> !laser_enable)
		else $error("laser on while off request held");
	ready_laser_a: assert property (tx_ready |-> laser_enable)
		else $error("ready without laser drive");
	fault_data_a: assert property (!tx_fault_out)
		else $error("fault pin data not low");
	fault_hold_a: assert property (flagged && !tx_off_request |-> !tx_fault_oe)
		else $error("fault flag dropped without reset sequence");
	los_follow_a: assert property (since_rx == LOS_LIM |-> rx_los == !rx_signal_present)
		else $error("loss indicator late");
	rate_drop_a: assert property (($changed(rate_select_zero) || $changed(rate_select_one))
		|-> ##[1:8] !rate_stable)
		else $error("rate stable not dropped after change");
	wire_up_a: assert property (since_reset == TW_LIM |-> two_wire_ready)
		else $error("management interface late");
	wire_keep_a: assert property (two_wire_ready |=> two_wire_ready)
		else $error("management ready dropped");
endmodule
bind optical_module_sideband_control sideband_asserts #(.TWO_WIRE_LEN(TWO_WIRE_LEN)) chk_u (
	.clock, .rst_n, .tx_off_request, .rate_select_zero, .rate_select_one, .fibre_channel_mode,
	.level2_stop_bit, .laser_fault, .rx_signal_present, .laser_enable, .tx_ready, .tx_fault_oe,
	.tx_fault_out, .rx_los, .two_wire_ready, .module_ready, .power_level2, .rate_stable);
`default_nettype wire

// >>> host_model.sv
// behavioural host controller on the module sideband pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clock,
	input wire logic off_cmd,
	input wire logic fault_oe,
	input wire logic fault_out,
	output var logic tx_off_request,
	output logic fault_pin
);
	initial tx_off_request = 1'b0;
	// off request changes just after an edge; the bench holds it 12 us to clear a fault
	always @(posedge clock) tx_off_request <= off_cmd;
	// pull-up on the open-drain fault pin
	assign fault_pin = fault_oe ? fault_out : 1'b1;
endmodule
`default_nettype wire

// >>> optical_module_sideband_control_tb_top.sv
// self-checking bench for the sideband controller
`timescale 1ns/1ps
`default_nettype none
module optical_module_sideband_control_tb_top;
	localparam int L = 20;
	localparam int US = 250;
	localparam int W = L * US + 300;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic off_cmd = 1'b0;
	logic rate_select_zero = 1'b0;
	logic rate_select_one = 1'b0;
	logic level2_stop_bit = 1'b0;
	logic laser_fault = 1'b0;
	logic rx_signal_present = 1'b1;
	logic fibre_channel_mode = 1'b0;
	logic tx_off_request, laser_enable, tx_ready, tx_fault_oe, tx_fault_out, rx_los;
	logic two_wire_ready, module_ready, power_level2, rate_stable, fault_pin;
	int bad_count = 0;
	int checks_done = 0;
	always #2 clock = ~clock;
	optical_module_sideband_control #(.START_LEN(L), .START_COOLED_LEN(L), .TWO_WIRE_LEN(L),
		.LEVEL2_UP_LEN(L), .LEVEL2_DOWN_LEN(L), .ON_LEN(L), .FAULT_LEN(L),
		.RATE_NON_FC_LEN(L)) dut_u (.clock, .rst_n, .tx_off_request, .rate_select_zero,
		.rate_select_one, .fibre_channel_mode, .level2_stop_bit, .laser_fault,
		.rx_signal_present, .laser_enable, .tx_ready, .tx_fault_oe, .tx_fault_out, .rx_los,
		.two_wire_ready, .module_ready, .power_level2, .rate_stable);
	host_model host_u (.clock, .off_cmd, .fault_oe(tx_fault_oe), .fault_out(tx_fault_out),
		.tx_off_request, .fault_pin);
	task automatic cycles(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic t_off_on();
		@(posedge clock) off_cmd <= 1'b1;
		cycles(1000);
		check_bit("laser after off", 1'b0, laser_enable);
		check_bit("ready after off", 1'b0, tx_ready);
		@(posedge clock) off_cmd <= 1'b0;
		cycles(W);
		check_bit("ready after on", 1'b1, tx_ready);
	endtask
	task automatic t_fault();
		@(posedge clock) laser_fault <= 1'b1;
		cycles(W);
		check_bit("fault flag", 1'b1, fault_pin);
		@(posedge clock) laser_fault <= 1'b0;
		off_cmd <= 1'b1;
		cycles(5 * US);
		@(posedge clock) off_cmd <= 1'b0;
		cycles(W);
		check_bit("fault after short pulse", 1'b1, fault_pin);
		@(posedge clock) off_cmd <= 1'b1;
		cycles(12 * US);
		check_bit("fault after hold", 1'b0, fault_pin);
		@(posedge clock) off_cmd <= 1'b0;
		cycles(W);
		check_bit("ready after recovery", 1'b1, module_ready);
		check_bit("laser after recovery", 1'b1, laser_enable);
	endtask
	task automatic t_rate();
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			if (i == 0) rate_select_zero <= 1'b1;
			else rate_select_one <= 1'b1;
			cycles(10);
			check_bit("stable after change", 1'b0, rate_stable);
			cycles(W);
			check_bit("stable after window", 1'b1, rate_stable);
		end
		// fibre channel window is 500 us, far beyond the shortened non-fc window
		@(posedge clock) begin
			fibre_channel_mode <= 1'b1;
			rate_select_zero <= 1'b0;
		end
		cycles(W);
		check_bit("stable in fc window", 1'b0, rate_stable);
	endtask
	task automatic t_level2();
		for (int i = 0; i < 2; i++) begin
			@(posedge clock) level2_stop_bit <= 1'b1;
			cycles(4);
			@(posedge clock) level2_stop_bit <= 1'b0;
			cycles(W);
			check_bit("power level two", i == 0, power_level2);
		end
	endtask
	task automatic t_los();
		check_bit("loss at rest", 1'b0, rx_los);
		@(posedge clock) rx_signal_present <= 1'b0;
		cycles(100 * US + 400);
		check_bit("loss after drop", 1'b1, rx_los);
	endtask
	task automatic complete_run();
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		@(posedge clock) rst_n <= 1'b1;
		cycles(W);
		check_bit("two wire ready", 1'b1, two_wire_ready);
		check_bit("module ready", 1'b1, module_ready);
		check_bit("laser at start", 1'b1, laser_enable);
		t_off_on();
		t_fault();
		t_rate();
		t_level2();
		t_los();
		complete_run();
	end
endmodule
`default_nettype wire
